/* File: rfsc_pkg.sv */
package rfsc_pkg;

  // Register indices (printed offsets are not multiples of four; byte address = 4 * index)
  localparam logic [7:0] IDX_SYNTH_MAIN = 8'h16;
  localparam logic [7:0] IDX_SYNTH_AUX = 8'h17;
  localparam logic [7:0] IDX_CONV_OUT = 8'h18;
  localparam logic [7:0] IDX_CONV_RESULT = 8'h19;
  localparam logic [7:0] IDX_RX_LEN_UPPER = 8'h1A;
  localparam logic [7:0] IDX_COMMAND = 8'h20;
  localparam logic [7:0] IDX_MEAS_SELECT = 8'h21;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h23;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] IDX_RX_LEN_LOWER = 8'h25;

  // Reset values
  localparam logic [23:0] SYNTH_MAIN_RST = 24'h40D84F;
  localparam logic [23:0] SYNTH_AUX_RST = 24'h011846;
  localparam logic [7:0] CONV_OUT_RST = 8'h00;
  localparam logic [7:0] RX_LEN_UPPER_RST = 8'h00;
  localparam logic [2:0] MEAS_SELECT_RST = 3'h0;

  // Field positions
  localparam int BIAS_BIT = 23;
  localparam int REF_HI = 22;
  localparam int REF_LO = 20;
  localparam int VCO_DIRECT_BIT = 22;
  localparam int EXT_SRC_BIT = 21;
  localparam int PRESC_EN_BIT = 20;
  localparam int BCNT_HI = 19;
  localparam int BCNT_LO = 10;
  localparam int ACNT_HI = 9;
  localparam int ACNT_LO = 0;
  localparam int NO_CHECK_BIT = 7;
  localparam int RAW_FIFO_BIT = 6;
  localparam int RXLEN_HI_HI = 1;
  localparam int RXLEN_HI_LO = 0;

  // Commands
  localparam logic [7:0] CMD_TRIGGER_CONV = 8'h87;

  // Interrupt status bits
  localparam int IRQ_CONV_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_W = 2;

  // Conversion time
  localparam int CLOCK_MHZ = 125;
  localparam int CONV_TIME_US = 20;
  localparam int CONV_CYCLES = CONV_TIME_US * CLOCK_MHZ;
  localparam logic [11:0] CONV_CYCLES_C = 12'(CONV_CYCLES);

  // Reference frequencies in kHz
  localparam logic [9:0] REF_KHZ_500 = 10'd500;
  localparam logic [9:0] REF_KHZ_250 = 10'd250;
  localparam logic [9:0] REF_KHZ_125 = 10'd125;
  localparam logic [9:0] REF_KHZ_200 = 10'd200;
  localparam logic [9:0] REF_KHZ_100 = 10'd100;
  localparam logic [9:0] REF_KHZ_50 = 10'd50;
  localparam logic [9:0] REF_KHZ_25 = 10'd25;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_BUSY
  } rfsc_conv_e;

endpackage : rfsc_pkg

/* File: rfsc_divider_decode.sv */
`timescale 1ns/100ps
module rfsc_divider_decode
  import rfsc_pkg::*;
(
  input wire logic [23:0] word,
  output logic [16:0] ratio
);

  // N = B*32 + A*33
  always_comb begin
    ratio = 17'({word[BCNT_HI:BCNT_LO], 5'h00}) + 17'({word[ACNT_HI:ACNT_LO], 5'h00})
      + 17'(word[ACNT_HI:ACNT_LO]);
  end

endmodule : rfsc_divider_decode

/* File: rfsc_converter.sv */
`timescale 1ns/100ps
module rfsc_converter
  import rfsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] measSelect,
  input wire logic [7:0] mixerLevelI,
  input wire logic [7:0] mixerLevelQ,
  input wire logic [7:0] pinLevel,
  output logic busy,
  output logic done,
  output logic [7:0] result
);

  rfsc_conv_e state_r;
  logic [11:0] count_r;
  logic [7:0] sample;

  // Source choice
  always_comb begin
    unique case (measSelect)
      3'h0: sample = mixerLevelI;
      3'h1: sample = mixerLevelQ;
      default: sample = pinLevel;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= CONV_IDLE;
      count_r <= 12'h000;
    end else begin
      unique case (state_r)
        CONV_IDLE: begin
          if (start) begin
            state_r <= CONV_BUSY;
            count_r <= CONV_CYCLES_C - 12'h001;
          end
        end
        CONV_BUSY: begin
          if (count_r == 12'h000) begin
            state_r <= CONV_IDLE;
          end else begin
            count_r <= count_r - 12'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      result <= 8'h00;
    end else if (state_r == CONV_BUSY && count_r == 12'h000) begin
      result <= sample;
    end
  end

  assign busy = state_r == CONV_BUSY;
  assign done = state_r == CONV_BUSY && count_r == 12'h000;

endmodule : rfsc_converter

/* File: rfsc_regs.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Main register bits 22:20 pick the reference frequency, with code 010 (125 kHz) only on one variant.
// - Both synthesizer registers hold B in 19:10 and A in 9:0 and divide by B*32 plus A*33.
// - Main bit 23 doubles the amplifier bias and auxiliary bit 23 quadruples it.
// - Auxiliary bit 21 picks external RF input when set, bit 22 picks direct oscillator connection.
// - Auxiliary bit 20 enables the divider and prescaler.
// - Reset or chip enable low presets the main register to 40 D8 4F.
// - Reset or chip enable low presets the auxiliary register to 01 18 46.
// - The 8-bit converter output level drives the DAC and clears to 00.
// - A 3-bit measurement select picks a mixer level or the external pin level.
// - Command 87 starts a conversion whose result is valid 20 us later.
// - Bit 7 of the upper receive length disables checking for the next reception only.
// - Bit 6 sends all bytes to the FIFO and remaps header and third error interrupts.
// - Bits 1:0 hold count bits 9:8, and the register clears on reset, enable low and good reception.
// - Bits 5 to 2 are reserved and read zero.
// - The receive count sets the bit count, and zero means end on pause.
module rfsc_regs
  import rfsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chipEnable,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire logic [7:0] mixerLevelI,
  input wire logic [7:0] mixerLevelQ,
  input wire logic [7:0] pinLevel,
  input wire logic rxStart,
  input wire logic rxGood,
  input wire logic rxHeaderIrq,
  input wire logic rxErr3Irq,
  output logic [9:0] referenceKhz,
  output logic referenceIllegal,
  output logic [16:0] mainRatio,
  output logic [16:0] auxRatio,
  output logic [1:0] paBiasBoost,
  output logic externalRfSelect,
  output logic vcoDirect,
  output logic prescalerEnable,
  output logic [7:0] dacLevel,
  output logic [9:0] rxBitCount,
  output logic rxEndOnPause,
  output logic rxCheckActive,
  output logic rxRawFifo,
  output logic rxSecondByteIrq,
  output logic rxFinishedIrq,
  output logic rxHeaderOut,
  output logic rxErr3Out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Chip enable synchroniser and preset condition
  logic enMeta_r;
  logic enSync_r;
  logic preset;

  always_ff @(posedge clock) begin
    if (rst) begin
      enMeta_r <= 1'b0;
      enSync_r <= 1'b0;
    end else begin
      enMeta_r <= chipEnable;
      enSync_r <= enMeta_r;
    end
  end

  assign preset = rst || !enSync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic rdAck_r;
  logic wrHit;
  logic rdReq;
  logic known;

  assign known = address inside {IDX_SYNTH_MAIN, IDX_SYNTH_AUX, IDX_CONV_OUT, IDX_CONV_RESULT,
    IDX_RX_LEN_UPPER, IDX_COMMAND, IDX_MEAS_SELECT, IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR,
    IDX_RX_LEN_LOWER};
  assign rdReq = read && !write;
  assign wrHit = write && !read;
  assign waitrequest = rdReq && !rdAck_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdAck_r <= 1'b0;
    end else begin
      rdAck_r <= rdReq && !rdAck_r;
    end
  end

  function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [23:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = d[7:0];
    end
    if (be[1]) begin
      res[15:8] = d[15:8];
    end
    if (be[2]) begin
      res[23:16] = d[23:16];
    end
    return res;
  endfunction : merge24

  ////////////////////////////////////////////////////////////////////////////////
  // Synthesizer registers
  logic [23:0] synthMain_r;
  logic [23:0] synthAux_r;

  always_ff @(posedge clock) begin
    if (preset) begin
      synthMain_r <= SYNTH_MAIN_RST;
    end else if (wrHit && address == IDX_SYNTH_MAIN) begin
      synthMain_r <= merge24(synthMain_r, writedata, byteenable);
    end
  end

  always_ff @(posedge clock) begin
    if (preset) begin
      synthAux_r <= SYNTH_AUX_RST;
    end else if (wrHit && address == IDX_SYNTH_AUX) begin
      synthAux_r <= merge24(synthAux_r, writedata, byteenable);
    end
  end

  always_comb begin
    referenceIllegal = 1'b0;
    unique case (synthMain_r[REF_HI:REF_LO])
      3'h0: referenceKhz = REF_KHZ_500;
      3'h1: referenceKhz = REF_KHZ_250;
      3'h2: referenceKhz = REF_KHZ_125;
      3'h4: referenceKhz = REF_KHZ_200;
      3'h5: referenceKhz = REF_KHZ_100;
      3'h6: referenceKhz = REF_KHZ_50;
      3'h7: referenceKhz = REF_KHZ_25;
      default: begin
        referenceKhz = REF_KHZ_500;
        referenceIllegal = 1'b1;
      end
    endcase
  end

  rfsc_divider_decode mainDiv (
    .word(synthMain_r),
    .ratio(mainRatio)
  );

  rfsc_divider_decode auxDiv (
    .word(synthAux_r),
    .ratio(auxRatio)
  );

  assign paBiasBoost = {synthAux_r[BIAS_BIT], synthMain_r[BIAS_BIT]};
  assign vcoDirect = synthAux_r[VCO_DIRECT_BIT];
  assign externalRfSelect = synthAux_r[EXT_SRC_BIT];
  assign prescalerEnable = synthAux_r[PRESC_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Converter output level and measurement select
  logic [7:0] convOut_r;
  logic [2:0] measSelect_r;

  always_ff @(posedge clock) begin
    if (preset) begin
      convOut_r <= CONV_OUT_RST;
    end else if (wrHit && address == IDX_CONV_OUT && byteenable[0]) begin
      convOut_r <= writedata[7:0];
    end
  end

  assign dacLevel = convOut_r;

  always_ff @(posedge clock) begin
    if (preset) begin
      measSelect_r <= MEAS_SELECT_RST;
    end else if (wrHit && address == IDX_MEAS_SELECT && byteenable[0]) begin
      measSelect_r <= writedata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion engine
  logic convStart;
  logic convBusy;
  logic convDone;
  logic [7:0] convResult;

  assign convStart = wrHit && address == IDX_COMMAND && byteenable[0] && writedata[7:0] == CMD_TRIGGER_CONV;

  rfsc_converter conv (
    .clock(clock),
    .rst(preset),
    .start(convStart),
    .measSelect(measSelect_r),
    .mixerLevelI(mixerLevelI),
    .mixerLevelQ(mixerLevelQ),
    .pinLevel(pinLevel),
    .busy(convBusy),
    .done(convDone),
    .result(convResult)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Receive length registers
  logic [7:0] rxUpper_r;
  logic [7:0] rxLower_r;
  logic noCheckLatched_r;

  always_ff @(posedge clock) begin
    if (preset || rxGood) begin
      rxUpper_r <= RX_LEN_UPPER_RST;
    end else if (wrHit && address == IDX_RX_LEN_UPPER && byteenable[0]) begin
      rxUpper_r <= {writedata[7:6], 4'h0, writedata[1:0]};
    end else if (rxStart) begin
      rxUpper_r[NO_CHECK_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (preset || rxGood) begin
      rxLower_r <= RX_LEN_UPPER_RST;
    end else if (wrHit && address == IDX_RX_LEN_LOWER && byteenable[0]) begin
      rxLower_r <= writedata[7:0];
    end
  end

  // Option captured for the reception in flight
  always_ff @(posedge clock) begin
    if (preset) begin
      noCheckLatched_r <= 1'b0;
    end else if (rxStart) begin
      noCheckLatched_r <= rxUpper_r[NO_CHECK_BIT];
    end
  end

  assign rxBitCount = {rxUpper_r[RXLEN_HI_HI:RXLEN_HI_LO], rxLower_r};
  assign rxEndOnPause = rxBitCount == 10'h000;
  assign rxCheckActive = !noCheckLatched_r;
  assign rxRawFifo = rxUpper_r[RAW_FIFO_BIT];
  assign rxSecondByteIrq = rxRawFifo && rxHeaderIrq;
  assign rxFinishedIrq = rxRawFifo && rxErr3Irq;
  assign rxHeaderOut = !rxRawFifo && rxHeaderIrq;
  assign rxErr3Out = !rxRawFifo && rxErr3Irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [IRQ_W-1:0] irqStatus_r;
  logic [IRQ_W-1:0] irqEnable_r;
  logic [IRQ_W-1:0] irqEvents;
  logic [IRQ_W-1:0] irqClear;

  assign irqEvents = {rxGood, convDone};
  assign irqClear = (wrHit && address == IDX_IRQ_CLEAR && byteenable[0]) ? writedata[IRQ_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (preset) begin
      irqStatus_r <= '0;
    end else begin
      irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
    end
  end

  always_ff @(posedge clock) begin
    if (preset) begin
      irqEnable_r <= '0;
    end else if (wrHit && address == IDX_IRQ_ENABLE && byteenable[0]) begin
      irqEnable_r <= writedata[IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus_r & irqEnable_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, result register has no write path
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h00000000;
      response <= 2'h0;
    end else if (rdReq && !rdAck_r) begin
      response <= known ? 2'h0 : 2'h2;
      unique case (address)
        IDX_SYNTH_MAIN: readdata <= {8'h00, synthMain_r};
        IDX_SYNTH_AUX: readdata <= {8'h00, synthAux_r};
        IDX_CONV_OUT: readdata <= {24'h000000, convOut_r};
        IDX_CONV_RESULT: readdata <= {24'h000000, convResult};
        IDX_RX_LEN_UPPER: readdata <= {24'h000000, rxUpper_r};
        IDX_RX_LEN_LOWER: readdata <= {24'h000000, rxLower_r};
        IDX_MEAS_SELECT: readdata <= {29'h00000000, measSelect_r};
        IDX_IRQ_STATUS: readdata <= {30'h00000000, irqStatus_r};
        IDX_IRQ_ENABLE: readdata <= {30'h00000000, irqEnable_r};
        IDX_COMMAND: readdata <= {31'h00000000, convBusy};
        default: readdata <= 32'h00000000;
      endcase
    end
  end

endmodule : rfsc_regs

/* File: rfsc_regs_asserts.sv */
`timescale 1ns/100ps
module rfsc_regs_asserts
  import rfsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic rxGood,
  input wire logic rxHeaderIrq,
  input wire logic rxErr3Irq,
  input wire logic [9:0] referenceKhz,
  input wire logic [16:0] mainRatio,
  input wire logic [16:0] auxRatio,
  input wire logic [1:0] paBiasBoost,
  input wire logic externalRfSelect,
  input wire logic vcoDirect,
  input wire logic prescalerEnable,
  input wire logic [7:0] dacLevel,
  input wire logic [9:0] rxBitCount,
  input wire logic rxEndOnPause,
  input wire logic rxRawFifo,
  input wire logic rxSecondByteIrq,
  input wire logic rxFinishedIrq
);
  logic [31:0] wdPrev_r;
  always_ff @(posedge clock) begin
    wdPrev_r <= writedata;
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] idx);
    write && !waitrequest && address == idx && byteenable == 4'hF;
  endsequence
  ////////////////////////////////////////
  a_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read answer timing wrong");
  a_reset_preset: assert property ($fell(rst) |-> mainRatio == 17'h10EF && auxRatio == 17'h11C6
    && referenceKhz == 10'h0C8 && dacLevel == 8'h00) else $error("preset values wrong");
  a_main_ratio: assert property (s_wr(IDX_SYNTH_MAIN) |=> paBiasBoost[0] == wdPrev_r[23]
    && mainRatio == wdPrev_r[19:10] * 32 + wdPrev_r[9:0] * 33) else $error("main fields wrong");
  a_aux_fields: assert property (s_wr(IDX_SYNTH_AUX) |=> auxRatio == wdPrev_r[19:10] * 32 + wdPrev_r[9:0] * 33
    && {paBiasBoost[1], vcoDirect, externalRfSelect, prescalerEnable} == wdPrev_r[23:20]) else $error("aux fields wrong");
  a_dac_level: assert property (s_wr(IDX_CONV_OUT) |=> dacLevel == wdPrev_r[7:0]) else $error("dac level wrong");
  a_end_pause: assert property (rxEndOnPause == (rxBitCount == 10'h000)) else $error("pause end wrong");
  a_header_remap: assert property (rxRawFifo && rxHeaderIrq |-> ##[0:1] rxSecondByteIrq)
    else $error("second byte irq missing");
  a_err3_remap: assert property (rxRawFifo && rxErr3Irq |-> ##[0:1] rxFinishedIrq) else $error("finish irq missing");
  a_good_clear: assert property (rxGood |-> ##[1:3] rxBitCount[9:8] == 2'h0) else $error("length not cleared");
endmodule : rfsc_regs_asserts

/* File: rfsc_rx_model.sv */
`timescale 1ns/100ps
module rfsc_rx_model (
  input wire logic clock,
  input wire logic go,
  input wire logic good,
  output logic rxStart,
  output logic rxGood,
  output logic rxHeaderIrq,
  output logic rxErr3Irq
);
  // Receiver stand-in: start, header, third error, then good pulse
  logic [2:0] step_r = 3'h0;
  always_ff @(posedge clock) begin
    if (go) begin
      step_r <= 3'h1;
    end else if (step_r != 3'h0) begin
      step_r <= (step_r == 3'h4) ? 3'h0 : step_r + 3'h1;
    end
  end
  assign rxStart = step_r == 3'h1;
  assign rxHeaderIrq = step_r == 3'h2;
  assign rxErr3Irq = step_r == 3'h3;
  assign rxGood = step_r == 3'h4 && good;
endmodule : rfsc_rx_model

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import rfsc_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, chipEnable = 1'b1, read = 1'b0, write = 1'b0, rxGo = 1'b0, rxOk = 1'b0;
  logic [7:0] address = 8'h00, mixerLevelI = 8'h00, mixerLevelQ = 8'h00, pinLevel = 8'h00, dacLevel;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [3:0] byteenable = 4'hF;
  logic [1:0] response, paBiasBoost;
  logic [9:0] referenceKhz, rxBitCount;
  logic [16:0] mainRatio, auxRatio;
  logic waitrequest, rxStart, rxGood, rxHeaderIrq, rxErr3Irq, referenceIllegal, externalRfSelect, vcoDirect;
  logic prescalerEnable, rxEndOnPause, rxCheckActive, rxRawFifo, rxSecondByteIrq, rxFinishedIrq, rxHeaderOut;
  logic rxErr3Out, irq;
  int failures = 0, tests_run = 0, n, lvl, low;
  int unsigned mdl [int];
  int kt [8] = '{500, 250, 125, 0, 200, 100, 50, 25};
  always #4 clock = ~clock;
  rfsc_regs dut (.*);
  rfsc_rx_model rx (.clock(clock), .go(rxGo), .good(rxOk), .rxStart(rxStart), .rxGood(rxGood),
    .rxHeaderIrq(rxHeaderIrq), .rxErr3Irq(rxErr3Irq));
  ////////////////////////////////////////
  task test_done;
    $display("Compares %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function int unsigned msk(input int a);
    case (a)
      8'h16, 8'h17: msk = 32'h00FFFFFF;
      8'h18: msk = 32'h000000FF;
      8'h1A: msk = 32'h000000C3;
      8'h21: msk = 32'h00000007;
      8'h23: msk = 32'h00000003;
      default: msk = 32'h0;
    endcase
  endfunction : msk
  function int ratio(input int unsigned w);
    return ((w >> 10) & 32'h3FF) * 32 + (w & 32'h3FF) * 33;
  endfunction : ratio
  task waitAck;
    int k;
    k = 0;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      k++;
      if (k > 20) begin
        failures++;
        test_done();
      end
      @(posedge clock);
    end
  endtask : waitAck
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    waitAck();
    write <= 1'b0;
    if (msk(a) != 0) mdl[a] = d & msk(a);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    waitAck();
    rd = readdata;
    read <= 1'b0;
    chk(rd, e);
  endtask : rdc
  task preset;
    mdl[8'h16] = 32'h40D84F;
    mdl[8'h17] = 32'h011846;
    mdl[8'h18] = 32'h0;
    mdl[8'h1A] = 32'h0;
  endtask : preset
  task checkAll;
    rdc(8'h16, mdl[8'h16]);
    rdc(8'h17, mdl[8'h17]);
    rdc(8'h18, mdl[8'h18]);
    rdc(8'h1A, mdl[8'h1A]);
    chk(mainRatio, ratio(mdl[8'h16]));
    chk(auxRatio, ratio(mdl[8'h17]));
    chk(paBiasBoost, {mdl[8'h17][23], mdl[8'h16][23]});
    chk({vcoDirect, externalRfSelect, prescalerEnable}, mdl[8'h17][22:20]);
    chk(dacLevel, mdl[8'h18][7:0]);
    chk({rxRawFifo, rxBitCount[9:8]}, {mdl[8'h1A][6], mdl[8'h1A][1:0]});
  endtask : checkAll
  task rxRun(input logic ok);
    @(posedge clock);
    rxOk <= ok;
    rxGo <= 1'b1;
    @(posedge clock);
    rxGo <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk(rxCheckActive, !mdl[8'h1A][7]);
    chk({rxSecondByteIrq, rxHeaderOut}, {mdl[8'h1A][6], !mdl[8'h1A][6]});
    @(negedge clock);
    chk({rxFinishedIrq, rxErr3Out}, {mdl[8'h1A][6], !mdl[8'h1A][6]});
    repeat (3) @(posedge clock);
    mdl[8'h1A] = ok ? 0 : mdl[8'h1A] & 32'h7F;
    checkAll();
  endtask : rxRun
  ////////////////////////////////////////
  initial begin
    void'($urandom(41));
    preset();
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    checkAll();
    $display("Test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h16, ($urandom & 32'h008FFFFF) | (c << 20));
      wr(8'h17, $urandom);
      wr(8'h18, $urandom);
      checkAll();
      if (c != 3) chk(referenceKhz, kt[c]);
      chk(referenceIllegal, c == 3);
    end
    $display("Test synth done");
    for (int m = 0; m < 8; m++) begin
      @(posedge clock);
      mixerLevelI <= 8'($urandom);
      mixerLevelQ <= 8'($urandom);
      pinLevel <= 8'($urandom);
      wr(8'h21, m);
      wr(8'h23, m != 7);
      wr(8'h20, CMD_TRIGGER_CONV);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge clock);
        n++;
      end
      if (m != 7) chk(n >= 2490 && n <= 2520, 1'b1);
      else chk(n, 3000);
      lvl = (m == 0) ? mixerLevelI : (m == 1) ? mixerLevelQ : pinLevel;
      rdc(8'h19, lvl);
      wr(8'h19, ~lvl);
      rdc(8'h19, lvl);
      rdc(8'h22, 32'h1);
      wr(8'h24, 32'h1);
      rdc(8'h22, 32'h0);
      chk(irq, 1'b0);
    end
    $display("Test converter done");
    low = 1 + ($urandom & 32'hFE);
    wr(8'h1A, 32'hFF);
    wr(8'h25, low);
    checkAll();
    chk(rxBitCount, {2'h3, low[7:0]});
    rxRun(1'b0);
    rxRun(1'b1);
    rxRun(1'b0);
    wr(8'h25, 32'h0);
    @(negedge clock);
    chk(rxEndOnPause, 1'b1);
    $display("Test receive length done");
    wr(8'h16, $urandom);
    wr(8'h18, $urandom);
    wr(8'h1A, $urandom);
    @(posedge clock);
    chipEnable <= 1'b0;
    repeat (4) @(posedge clock);
    chipEnable <= 1'b1;
    repeat (4) @(posedge clock);
    preset();
    checkAll();
    rdc(8'h30, 32'h0);
    chk(response, 2'h2);
    $display("Test enable and unmapped done");
    test_done();
  end
endmodule : tb_top
bind rfsc_regs rfsc_regs_asserts u_chk (.*);
